// file: rtl/lfm_map.svh
// constants of the loop fault monitor: addresses, field widths, timing
`ifndef LFM_MAP_SVH
`define LFM_MAP_SVH

// frame layout
`define LFM_FRAME_BITS 24
`define LFM_CMD_MSB 23
`define LFM_CMD_LSB 16
`define LFM_READ_BIT 7

// register addresses seen in the command byte
`define LFM_ADDR_NONE 7'h00
`define LFM_ADDR_CODE 7'h04
`define LFM_ADDR_STATUS 7'h05
`define LFM_ADDR_ERR_STATUS 7'h09

// timing
`define LFM_CLK_KHZ 125000
`define LFM_TIMEOUT_MS 100
`define LFM_RETRY_UNIT_MS 50
`define LFM_SETTLE_US 10
`define LFM_CLK_MHZ 125

// synchronised pin count and count width
`define LFM_SYNC_BITS 5
`define LFM_CNT_W 32

// pin levels at rest: only chip select idles high
`define LFM_PIN_IDLE 5'h02

`endif

// file: rtl/lfm_pkg.sv
// types shared by the loop fault monitor
package lfm_pkg;

    // what the loop driver is told to produce
    typedef enum logic [1:0] {
        LFM_DRIVE_CODE = 2'b00,
        LFM_DRIVE_LOW = 2'b01,
        LFM_DRIVE_HIGH = 2'b10
    } lfm_drive_t;

    // loop supervision states
    typedef enum logic [1:0] {
        LFM_LOOP_OK = 2'b00,
        LFM_LOOP_ALARM = 2'b01,
        LFM_LOOP_TRY = 2'b10
    } lfm_loop_t;

    // configuration bits from the error configuration register
    typedef struct packed {
        logic loop_alarm_mask;
        logic retry_disable;
        logic [2:0] retry_interval;
        logic loop_fault_pin_disable;
        logic link_timeout_mask;
        logic link_timeout_loop_mask;
    } lfm_cfg_t;

    // read-only status flags
    typedef struct packed {
        logic framing_fault_flag;
        logic loop_fault_live_flag;
        logic loop_fault_sticky_flag;
        logic link_timeout_flag;
    } lfm_status_t;

endpackage : lfm_pkg

// file: rtl/lfm_monitor.sv
// fault detection and alarm reporting of a current-loop output converter
`timescale 1ns/1ps
`include "lfm_map.svh"

// Operation
// - loop fault switches output to low alarm current unless loop alarm mask set
// - unmasked loop fault retries restoring the code current every retry interval
// - successful restore attempt ends loop fault reporting
// - retry disable skips periodic checks; recheck only after error status read or code write
// - recheck finding fault still present returns to the low alarm current after settling
// - loop fault sets live and sticky flags; sticky clears on status read
// - live flag clears on successful restore, whether periodic or started by a new output code
// - master writes within watchdog period, else link timeout fault is flagged
// - writes with framing fault never restart the link watchdog
// - write to address zero is not valid and does not restart watchdog
// - timeout mask hides timeout on loop and pin; loop mask only loop
// - framing fault when clock pulse count is not a multiple of 24
// - framing fault always pulls fault pin low, no mask
// - framing fault leaves loop current unchanged
// - link timeout on loop uses band pin: low selects low, high selects high
// - loop fault and link timeout together drive the low alarm current
// - status holds framing, two loop and link timeout flags
// - loop fault pulls fault pin low unless loop fault pin disable is set
// - chip select rising before 24th clock edge aborts with framing fault
// - link watchdog period defaults to 100 ms
module lfm_monitor
    import lfm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `LFM_TIMEOUT_MS * `LFM_CLK_KHZ,
    parameter int RETRY_UNIT_CYCLES = `LFM_RETRY_UNIT_MS * `LFM_CLK_KHZ,
    parameter int SETTLE_CYCLES = `LFM_SETTLE_US * `LFM_CLK_MHZ
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic chip_select_n,
    input wire logic sdi,
    input wire logic loop_regulation_lost,
    input wire logic alarm_band_select_pin,
    input wire lfm_cfg_t cfg,
    output lfm_drive_t loop_drive,
    output logic fault_pin_n,
    output lfm_status_t status
);

    localparam int CW = `LFM_CNT_W;
    localparam int SB = `LFM_SYNC_BITS;
    localparam int FB = `LFM_FRAME_BITS;
    localparam logic [4:0] LAST_BIT = 5'(FB - 1);
    localparam logic [CW-1:0] TOUT_LAST = CW'(TIMEOUT_CYCLES - 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES - 1);
    localparam logic [CW-1:0] RETRY_UNIT = CW'(RETRY_UNIT_CYCLES);
    // resting pin levels; every sync stage starts there so release makes no edge
    localparam logic [SB-1:0] PIN_IDLE = `LFM_PIN_IDLE;

    // three-stage synchronisers for every pin from outside the clock;
    // the agree filter below costs a cycle of latency but hides a
    // one-cycle glitch on a pin; stages reset to the resting levels,
    // else a false select edge would follow every reset
    logic [SB-1:0] pin_raw;
    logic [SB-1:0] sync1_reg;
    logic [SB-1:0] sync2_reg;
    logic [SB-1:0] sync3_reg;
    logic [SB-1:0] clean_reg;
    logic [SB-1:0] clean_next;

    assign pin_raw = {alarm_band_select_pin, loop_regulation_lost, sdi, chip_select_n, sclk};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= PIN_IDLE;
            sync2_reg <= PIN_IDLE;
            sync3_reg <= PIN_IDLE;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SB; gi++)
        begin : g_clean
            assign clean_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi]
                                                                     : clean_reg[gi];
        end
    endgenerate

    // chip select idles high so its filtered copy resets high;
    // any other reset level would look like a frame start
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            clean_reg <= PIN_IDLE;
        else
            clean_reg <= clean_next;
    end

    // named views of the filtered pins;
    // nothing downstream ever reads a raw pin
    logic sclk_q;
    logic cs_n_q;
    logic sdi_q;
    logic loop_lost_q;
    logic band_high_q;
    logic sclk_prev_reg;
    logic cs_prev_reg;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    assign sclk_q = clean_reg[0];
    assign cs_n_q = clean_reg[1];
    assign sdi_q = clean_reg[2];
    assign loop_lost_q = clean_reg[3];
    assign band_high_q = clean_reg[4];

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end
        else
        begin
            sclk_prev_reg <= sclk_q;
            cs_prev_reg <= cs_n_q;
        end
    end

    // edge events of the serial link
    // clock edges with select high are ignored, so stray pulses count nothing
    assign sclk_rise = sclk_q && !sclk_prev_reg && !cs_n_q;
    assign cs_fall = !cs_n_q && cs_prev_reg;
    assign cs_rise = cs_n_q && !cs_prev_reg;

    // frame capture: bit position modulo 24 and a seen-a-whole-frame flag
    // counting modulo 24 lets 48 or 72 pulses pass as whole frames
    logic [FB-1:0] shift_reg;
    logic [4:0] bitpos_reg;
    logic whole_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            shift_reg <= '0;
            bitpos_reg <= '0;
            whole_reg <= 1'b0;
        end
        else if (cs_fall)
        begin
            bitpos_reg <= '0;
            whole_reg <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shift_reg <= {shift_reg[FB-2:0], sdi_q};
            bitpos_reg <= (bitpos_reg == LAST_BIT) ? 5'h00 : bitpos_reg + 5'h01;
            whole_reg <= whole_reg || (bitpos_reg == LAST_BIT);
        end
    end

    // decode of the last 24 bits when chip select rises
    // earlier words of a long frame are simply shifted out and dropped
    logic frame_ok;
    logic frame_bad;
    logic is_read;
    logic [6:0] cmd_addr;
    logic valid_write;
    logic code_write;
    logic status_read;
    logic err_status_read;

    assign frame_ok = cs_rise && whole_reg && (bitpos_reg == 5'h00);
    assign frame_bad = cs_rise && !frame_ok;
    assign is_read = shift_reg[`LFM_CMD_LSB + `LFM_READ_BIT];
    assign cmd_addr = shift_reg[`LFM_CMD_LSB + 6:`LFM_CMD_LSB];
    assign valid_write = frame_ok && !is_read && (cmd_addr != `LFM_ADDR_NONE);
    assign code_write = valid_write && (cmd_addr == `LFM_ADDR_CODE);
    assign status_read = frame_ok && is_read && (cmd_addr == `LFM_ADDR_STATUS);
    assign err_status_read = frame_ok && is_read && (cmd_addr == `LFM_ADDR_ERR_STATUS);

    // link watchdog: only clean, non-zero-address writes restart it
    // the count saturates at its last value, so the flag stands
    // until the next valid write rather than pulsing once
    logic [CW-1:0] wdog_reg;
    logic wdog_expire;

    assign wdog_expire = (wdog_reg == TOUT_LAST) && !valid_write;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wdog_reg <= '0;
        else if (valid_write)
            wdog_reg <= '0;
        else if (wdog_reg != TOUT_LAST)
            wdog_reg <= wdog_reg + 1'b1;
    end

    // loop supervision: alarm, wait, try to restore, judge after settling
    // one counter serves both the retry gap and the settle time; it is
    // cleared on every state change but the masked return to ok, so the two never mix
    // limitation: a retry field change only takes effect at the next compare
    lfm_loop_t loop_reg;
    lfm_loop_t loop_next;
    logic [CW-1:0] wait_reg;
    logic [CW-1:0] wait_next;
    logic [CW-1:0] retry_gap;
    logic retry_due;
    logic settled;

    assign retry_gap = RETRY_UNIT * CW'({1'b0, cfg.retry_interval} + 4'h1);
    assign retry_due = cfg.retry_disable ? err_status_read
                                         : (wait_reg >= retry_gap - 1'b1);
    assign settled = (wait_reg == SETTLE_LAST);

    // masked loop alarms never leave the ok state; the live flag still follows
    always_comb
    begin
        loop_next = loop_reg;
        wait_next = wait_reg + 1'b1;
        case (loop_reg)
            LFM_LOOP_OK:
            begin
                wait_next = '0;
                if (loop_lost_q && !cfg.loop_alarm_mask)
                    loop_next = LFM_LOOP_ALARM;
            end
            LFM_LOOP_ALARM:
            begin
                if (cfg.loop_alarm_mask)
                    loop_next = LFM_LOOP_OK;
                else if (retry_due || code_write)
                begin
                    loop_next = LFM_LOOP_TRY;
                    wait_next = '0;
                end
            end
            LFM_LOOP_TRY:
            begin
                if (settled)
                begin
                    wait_next = '0;
                    loop_next = loop_lost_q ? LFM_LOOP_ALARM : LFM_LOOP_OK;
                end
            end
            default:
            begin
                loop_next = LFM_LOOP_OK;
                wait_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            loop_reg <= LFM_LOOP_OK;
            wait_reg <= '0;
        end
        else
        begin
            loop_reg <= loop_next;
            wait_reg <= wait_next;
        end
    end

    // flag sources; every hardware set wins over a read that clears
    // a read in the same cycle as a new fault leaves the flag up, so none is lost
    logic loop_live;
    logic link_timeout_next;
    logic sticky_next;
    logic framing_next;

    assign loop_live = cfg.loop_alarm_mask ? loop_lost_q
                                           : (loop_next != LFM_LOOP_OK);
    assign link_timeout_next = wdog_expire || (status.link_timeout_flag && !valid_write);
    assign sticky_next = loop_live || (status.loop_fault_sticky_flag && !status_read);
    assign framing_next = frame_bad || (status.framing_fault_flag && !status_read);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            status <= '0;
        else
        begin
            status.framing_fault_flag <= framing_next;
            status.loop_fault_live_flag <= loop_live;
            status.loop_fault_sticky_flag <= sticky_next;
            status.link_timeout_flag <= link_timeout_next;
        end
    end

    // alarm current choice; framing faults play no part here
    // the loop fault is tested first so it wins over a high timeout band
    logic loop_alarm_on;
    logic link_on_loop;
    lfm_drive_t drive_next;

    assign loop_alarm_on = (loop_next == LFM_LOOP_ALARM);
    assign link_on_loop = link_timeout_next && !cfg.link_timeout_mask
                          && !cfg.link_timeout_loop_mask;
    assign drive_next = loop_alarm_on ? LFM_DRIVE_LOW
                      : link_on_loop ? (band_high_q ? LFM_DRIVE_HIGH : LFM_DRIVE_LOW)
                      : LFM_DRIVE_CODE;

    // fault pin: low while any enabled fault stands
    // framing faults have no mask here, by intent
    logic pin_low_next;

    assign pin_low_next = framing_next
                       || (loop_live && !cfg.loop_fault_pin_disable)
                       || (link_timeout_next && !cfg.link_timeout_mask);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            loop_drive <= LFM_DRIVE_CODE;
            fault_pin_n <= 1'b1;
        end
        else
        begin
            loop_drive <= drive_next;
            fault_pin_n <= !pin_low_next;
        end
    end

endmodule : lfm_monitor

// file: sim/lfm_monitor_properties.sv
// concurrent checks on the loop fault monitor ports
`timescale 1ns/1ps
module lfm_monitor_properties
    import lfm_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 2000
)
(
    input logic clk,
    input logic nrst,
    input logic chip_select_n,
    input logic alarm_band_select_pin,
    input lfm_cfg_t cfg,
    input lfm_drive_t loop_drive,
    input logic fault_pin_n,
    input lfm_status_t status
);
    int idle_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // cycles with select high; saturates so it never wraps
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            idle_cnt <= 0;
        else if (!chip_select_n)
            idle_cnt <= 0;
        else if (idle_cnt < TIMEOUT_CYCLES + 20)
            idle_cnt <= idle_cnt + 1;
    end
    // outputs tied to the fault that caused them
    property p_frame_pin; status.framing_fault_flag |-> ##[0:1] !fault_pin_n; endproperty
    a_frame_pin: assert property (p_frame_pin) else $error("framing pin high");
    property p_frame_loop; $rose(status.framing_fault_flag) && $stable(status.link_timeout_flag)
        && !status.loop_fault_live_flag |-> $stable(loop_drive); endproperty
    a_frame_loop: assert property (p_frame_loop) else $error("framing moved loop");
    property p_loop_low; $rose(status.loop_fault_live_flag) && !cfg.loop_alarm_mask
        |-> ##[0:1] loop_drive == LFM_DRIVE_LOW; endproperty
    a_loop_low: assert property (p_loop_low) else $error("loop alarm not low");
    property p_sticky; $rose(status.loop_fault_live_flag) |-> status.loop_fault_sticky_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("sticky flag missing");
    property p_loop_pin; $rose(status.loop_fault_live_flag) && !cfg.loop_fault_pin_disable
        |-> ##[0:1] !fault_pin_n; endproperty
    a_loop_pin: assert property (p_loop_pin) else $error("loop pin high");
    property p_tout_band; $rose(status.link_timeout_flag) && !cfg.link_timeout_mask
        && !cfg.link_timeout_loop_mask && !status.loop_fault_live_flag |-> ##[0:1]
        loop_drive == (alarm_band_select_pin ? LFM_DRIVE_HIGH : LFM_DRIVE_LOW); endproperty
    a_tout_band: assert property (p_tout_band) else $error("timeout band wrong");
    property p_tout_mask; (cfg.link_timeout_mask || cfg.link_timeout_loop_mask) && $stable(cfg)
        |-> loop_drive != LFM_DRIVE_HIGH; endproperty
    a_tout_mask: assert property (p_tout_mask) else $error("masked timeout on loop");
    property p_watchdog; idle_cnt == TIMEOUT_CYCLES + 12 && !cfg.link_timeout_mask
        |-> status.link_timeout_flag; endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog silent");
    c_frame: cover property ($rose(status.framing_fault_flag));
    c_restore: cover property ($fell(status.loop_fault_live_flag));
    c_high: cover property (loop_drive == LFM_DRIVE_HIGH);
endmodule : lfm_monitor_properties

bind lfm_monitor lfm_monitor_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    lfm_monitor_properties_i (.clk(clk), .nrst(nrst), .chip_select_n(chip_select_n),
    .alarm_band_select_pin(alarm_band_select_pin), .cfg(cfg), .loop_drive(loop_drive),
    .fault_pin_n(fault_pin_n), .status(status));

// file: sim/lfm_spi_master_model.sv
// serial master model: frames of any pulse count
`timescale 1ns/1ps
module lfm_spi_master_model
(
    output logic sclk,
    output logic chip_select_n,
    output logic sdi
);
    // idle: select high, clock parked low
    initial
    begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        sdi = 1'b0;
    end
    // msb first; word repeats, so at a multiple of 24 pulses the last 24 bits are the word
    task automatic send(input logic [23:0] word, input int pulses);
        int i;
        #37 chip_select_n = 1'b0;
        for (i = 0; i < pulses; i++)
        begin
            sdi = word[23 - (i % 24)];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        #80 chip_select_n = 1'b1;
        sdi = ~sdi; // released line must not show a stale bit
        #200;
    endtask : send
endmodule : lfm_spi_master_model

// file: sim/lfm_monitor_tb_top.sv
// self-checking bench of the loop fault monitor
`timescale 1ns/1ps
module lfm_monitor_tb_top;
    import lfm_pkg::*;
    localparam int TOUT = 2000;
    localparam int UNIT = 100;
    localparam int SETTLE = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk;
    logic chip_select_n;
    logic sdi;
    logic lost = 1'b0;
    logic band = 1'b0;
    lfm_cfg_t cfg = 8'h02;
    lfm_drive_t loop_drive;
    logic fault_pin_n;
    lfm_status_t status;
    int errors = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    lfm_monitor #(.TIMEOUT_CYCLES(TOUT), .RETRY_UNIT_CYCLES(UNIT), .SETTLE_CYCLES(SETTLE))
        lfm_monitor_i (.clk(clk), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
        .sdi(sdi), .loop_regulation_lost(lost), .alarm_band_select_pin(band), .cfg(cfg),
        .loop_drive(loop_drive), .fault_pin_n(fault_pin_n), .status(status));
    lfm_spi_master_model lfm_spi_master_model_i (.sclk(sclk), .chip_select_n(chip_select_n),
        .sdi(sdi));
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk
    // one frame with random data, then room for sync and decode
    task automatic frame(input logic [7:0] cmd, input int pulses);
        lfm_spi_master_model_i.send({cmd, 16'($urandom)}, pulses);
        repeat (10) @(posedge clk);
    endtask : frame
    // bounded wait for the watchdog flag
    task automatic wait_tout;
        int n;
        n = 0;
        while (status.link_timeout_flag !== 1'b1)
        begin
            @(posedge clk);
            n++;
            if (n > 3 * TOUT)
            begin
                errors++;
                report_and_stop();
            end
        end
    endtask : wait_tout
    // main sequence
    initial
    begin
        int i;
        int p;
        longint t0;
        p = $urandom(58);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        chk(status === '0 && fault_pin_n === 1'b1 && loop_drive === LFM_DRIVE_CODE, "rst");
        frame(8'h04, 48);
        chk(status.framing_fault_flag === 1'b0 && fault_pin_n === 1'b1, "48 flagged");
        // bad pulse counts, each cleared by a status read
        for (i = 0; i < 4; i++)
        begin
            p = (i == 3) ? 25 : 1 + $urandom_range(22);
            frame(8'h04, p);
            chk(status.framing_fault_flag === 1'b1, "framing");
            chk(fault_pin_n === 1'b0, "framing pin");
            chk(loop_drive === LFM_DRIVE_CODE, "loop moved");
            frame(8'h85, 24);
            chk(status.framing_fault_flag === 1'b0 && fault_pin_n === 1'b1, "stuck");
        end
        // address zero and broken frames leave the watchdog running
        for (i = 0; i < 2; i++)
        begin
            band <= i[0];
            cfg <= '0;
            frame(8'h04, 24);
            t0 = $time;
            frame(8'h00, 24);
            frame(8'h04, 23);
            wait_tout();
            p = int'(($time - t0) / 8);
            chk(p > TOUT - 50 && p < TOUT - 10, "watchdog time");
            repeat (2) @(posedge clk);
            chk(loop_drive === (i ? LFM_DRIVE_HIGH : LFM_DRIVE_LOW), "band");
        end
        lost <= 1'b1;
        repeat (10) @(posedge clk);
        chk(loop_drive === LFM_DRIVE_LOW, "priority");
        lost <= 1'b0;
        frame(8'h85, 24);
        // each timeout mask alone: loop quiet, pin per mask
        for (i = 0; i < 2; i++)
        begin
            cfg <= lfm_cfg_t'(8'h01 << i);
            frame(8'h04, 24);
            repeat (TOUT + 20) @(posedge clk);
            chk(loop_drive === LFM_DRIVE_CODE && fault_pin_n === i[0], "mask");
        end
        // loop fault with periodic retry, then with retry disabled
        for (i = 0; i < 2; i++)
        begin
            p = $urandom_range(7);
            cfg <= lfm_cfg_t'({1'b0, i[0], p[2:0], 3'b010});
            lost <= 1'b1;
            repeat (10) @(posedge clk);
            chk(loop_drive === LFM_DRIVE_LOW && status[2:1] === 2'b11, "alarm");
            chk(fault_pin_n === 1'b0, "alarm pin");
            if (i)
            begin
                frame(8'h89, 24);
                chk(loop_drive === LFM_DRIVE_LOW, "recheck");
            end
            lost <= 1'b0;
            repeat (UNIT * (p + 1) + SETTLE + 20) @(posedge clk);
            chk((loop_drive === LFM_DRIVE_LOW) === i[0], "retry");
            if (i)
                frame(8'h89, 24);
            repeat (SETTLE + 10) @(posedge clk);
            chk(loop_drive === LFM_DRIVE_CODE && status[2:1] === 2'b01, "restore");
            frame(8'h85, 24);
            chk(status[3:1] === 3'b000 && fault_pin_n === 1'b1, "sticky");
        end
        // a new output code ends a held loop fault; then a reset mid-run clears all
        cfg <= 8'h42;
        lost <= 1'b1;
        repeat (10) @(posedge clk);
        lost <= 1'b0;
        repeat (10) @(posedge clk);
        chk(loop_drive === LFM_DRIVE_LOW, "no retry");
        frame(8'h04, 24);
        chk(loop_drive === LFM_DRIVE_CODE && status[2:1] === 2'b01, "code write");
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        chk(status === '0 && fault_pin_n === 1'b1 && loop_drive === LFM_DRIVE_CODE, "rst2");
        // masked loop fault, pin report disabled
        cfg <= 8'h86;
        lost <= 1'b1;
        repeat (10) @(posedge clk);
        chk(loop_drive === LFM_DRIVE_CODE && fault_pin_n === 1'b1, "masked");
        report_and_stop();
    end
endmodule : lfm_monitor_tb_top
